// ---- design/cce_pkg.sv ----
// Functional notes
// [RULE1] status bit 1 reads 1 when idle
// [RULE2] control bit 12 enables completion interrupt
// [RULE3] source address register at 0x0018
// [RULE4] destination address register at 0x0020
// [RULE5] byte count write at 0x0028 launches transfer
// [RULE6] host polls idle before next launch
// [RULE7] window upper at 0x1208, lower at 0x120c
// [RULE8] aperture address is base plus low 19 bits
// [RULE9] aperture 0x00080000..0x000fffff goes to host
// [RULE10] host address joins window bits with offset
// [RULE11] bridge turns accesses into host requests
// [RULE12] range 0x1148..0x1204 reads zero, no function
// [RULE13] two independent host window register pairs
// [RULE14] zero byte count flags error, stays idle
// [RULE15] idle drops at launch, returns after last write
package cce_pkg;
   // register offsets in the host register window
   localparam logic [15:0] OFS_CTRL = 16'h0000;
   localparam logic [15:0] OFS_STAT = 16'h0004;
   localparam logic [15:0] OFS_SRC = 16'h0018;
   localparam logic [15:0] OFS_DST = 16'h0020;
   localparam logic [15:0] OFS_BTT = 16'h0028;
   localparam logic [15:0] OFS_PHY = 16'h1144;
   localparam logic [15:0] OFS_UNUSED_LO = 16'h1148;
   localparam logic [15:0] OFS_UNUSED_HI = 16'h1204;
   localparam logic [15:0] OFS_W0U = 16'h1208;
   localparam logic [15:0] OFS_W0L = 16'h120c;
   localparam logic [15:0] OFS_W1U = 16'h1210;
   localparam logic [15:0] OFS_W1L = 16'h1214;
   // field positions
   localparam int STAT_IDLE_BIT = 1;
   localparam int STAT_ERR_BIT = 4;
   localparam int CTRL_IRQ_BIT = 12;
   localparam int CTRL_WSEL_BIT = 16;
   // host aperture on the internal bus
   localparam logic [31:0] APER_BASE = 32'h0008_0000;
   localparam logic [31:0] APER_LAST = 32'h000f_ffff;
   localparam int APER_BITS = 19;
   localparam int BTT_W = 23;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] ADDR_RST = 32'h0000_0000;
   // engine states
   typedef enum logic [2:0] {ST_IDLE, ST_RD_REQ, ST_RD_WAIT, ST_WR_REQ, ST_WR_WAIT} cce_state_e;
   // whole module state
   typedef struct packed {
      cce_state_e st;
      logic [31:0] ctrl;
      logic [31:0] src;
      logic [31:0] dst;
      logic [BTT_W-1:0] btt;
      logic [1:0][31:0] win_up;
      logic [1:0][31:0] win_lo;
      logic idle;
      logic err;
      logic [7:0] data;
      logic [31:0] rdata;
      logic rvalid;
      logic irq;
      logic loc_req;
      logic loc_we;
      logic [31:0] loc_addr;
      logic host_req;
      logic host_we;
      logic [63:0] host_addr;
      logic [7:0] wdata;
   } cce_state_s;
endpackage : cce_pkg

// ---- design/cce_copy_engine.sv ----
`timescale 1ns/1ps
module cce_copy_engine (
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_n_in,
   // host register window, inbound requests
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   output logic [31:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // link status from the phy
   input wire logic [31:0] phy_status_in,
   // engine status
   output logic idle_out,
   output logic irq_out,
   // local internal bus master
   output logic loc_req_out,
   output logic loc_we_out,
   output logic [31:0] loc_addr_out,
   output logic [7:0] loc_wdata_out,
   input wire logic loc_ack_in,
   input wire logic [7:0] loc_rdata_in,
   // outbound host memory requests
   output logic host_req_out,
   output logic host_we_out,
   output logic [63:0] host_addr_out,
   output logic [7:0] host_wdata_out,
   input wire logic host_ack_in,
   input wire logic [7:0] host_rdata_in
);
   // registered state and its next value
   cce_pkg::cce_state_s s_r;
   cce_pkg::cce_state_s s_nxt;

   // true when an internal address falls in the host aperture
   function automatic logic in_aper(input logic [31:0] a);
      in_aper = (a >= cce_pkg::APER_BASE) && (a <= cce_pkg::APER_LAST); // [RULE9]
   endfunction : in_aper

   // host address: window bits above, aperture offset below
   function automatic logic [63:0] xlate(input logic [31:0] up, input logic [31:0] lo, input logic [31:0] a);
      xlate = {up, lo[31:cce_pkg::APER_BITS], a[cce_pkg::APER_BITS-1:0]}; // [RULE8] [RULE10]
   endfunction : xlate

   // decoded register strobes
   logic wr_btt;
   assign wr_btt = reg_wr_in && (reg_addr_in == cce_pkg::OFS_BTT);

   // next-state logic
   always_comb begin
      logic [31:0] a;
      logic sel;
      a = 32'h0;
      sel = s_r.ctrl[cce_pkg::CTRL_WSEL_BIT];
      s_nxt = s_r;
      s_nxt.irq = 1'b0;
      s_nxt.rvalid = 1'b0;
      // register writes; address and count are locked while busy
      if (reg_wr_in) begin
         case (reg_addr_in)
            cce_pkg::OFS_CTRL: s_nxt.ctrl = reg_wdata_in; // [RULE2]
            cce_pkg::OFS_STAT: begin
               // write one clears the error flag
               if (reg_wdata_in[cce_pkg::STAT_ERR_BIT]) begin
                  s_nxt.err = 1'b0;
               end
            end
            cce_pkg::OFS_SRC: if (s_r.idle) s_nxt.src = reg_wdata_in; // [RULE3]
            cce_pkg::OFS_DST: if (s_r.idle) s_nxt.dst = reg_wdata_in; // [RULE4]
            cce_pkg::OFS_W0U: s_nxt.win_up[0] = reg_wdata_in; // [RULE7] [RULE13]
            cce_pkg::OFS_W0L: s_nxt.win_lo[0] = reg_wdata_in; // [RULE7] [RULE13]
            cce_pkg::OFS_W1U: s_nxt.win_up[1] = reg_wdata_in; // [RULE13]
            cce_pkg::OFS_W1L: s_nxt.win_lo[1] = reg_wdata_in; // [RULE13]
            default: ; // byte count handled by the engine, others ignored
         endcase
      end
      // register reads, answered one cycle later
      if (reg_rd_in) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = 32'h0;
         case (reg_addr_in)
            cce_pkg::OFS_CTRL: s_nxt.rdata = s_r.ctrl;
            cce_pkg::OFS_STAT: begin
               s_nxt.rdata[cce_pkg::STAT_IDLE_BIT] = s_r.idle; // [RULE1]
               s_nxt.rdata[cce_pkg::STAT_ERR_BIT] = s_r.err;
            end
            cce_pkg::OFS_SRC: s_nxt.rdata = s_r.src;
            cce_pkg::OFS_DST: s_nxt.rdata = s_r.dst;
            cce_pkg::OFS_BTT: s_nxt.rdata = {9'h0, s_r.btt};
            cce_pkg::OFS_PHY: s_nxt.rdata = phy_status_in;
            cce_pkg::OFS_W0U: s_nxt.rdata = s_r.win_up[0];
            cce_pkg::OFS_W0L: s_nxt.rdata = s_r.win_lo[0];
            cce_pkg::OFS_W1U: s_nxt.rdata = s_r.win_up[1];
            cce_pkg::OFS_W1L: s_nxt.rdata = s_r.win_lo[1];
            default: s_nxt.rdata = 32'h0; // unused bridge range and holes read zero [RULE12]
         endcase
      end
      // copy engine, one byte per read/write pair
      case (s_r.st)
         cce_pkg::ST_IDLE: begin
            if (wr_btt) begin // [RULE5]
               if (reg_wdata_in[cce_pkg::BTT_W-1:0] == 23'h0) begin
                  s_nxt.err = 1'b1; // halt at once, idle stays set [RULE14]
               end else begin
                  s_nxt.btt = reg_wdata_in[cce_pkg::BTT_W-1:0];
                  s_nxt.idle = 1'b0; // [RULE15]
                  s_nxt.st = cce_pkg::ST_RD_REQ;
               end
            end
         end
         cce_pkg::ST_RD_REQ: begin
            // read from host window or local bus [RULE11]
            a = s_r.src;
            s_nxt.loc_we = 1'b0;
            s_nxt.host_we = 1'b0;
            if (in_aper(a)) begin
               s_nxt.host_req = 1'b1;
               s_nxt.host_addr = xlate(s_r.win_up[sel], s_r.win_lo[sel], a); // [RULE10]
            end else begin
               s_nxt.loc_req = 1'b1;
               s_nxt.loc_addr = a;
            end
            s_nxt.st = cce_pkg::ST_RD_WAIT;
         end
         cce_pkg::ST_RD_WAIT: begin
            // capture the byte from whichever path answered
            if (s_r.host_req && host_ack_in) begin
               s_nxt.host_req = 1'b0;
               s_nxt.data = host_rdata_in;
               s_nxt.st = cce_pkg::ST_WR_REQ;
            end else if (s_r.loc_req && loc_ack_in) begin
               s_nxt.loc_req = 1'b0;
               s_nxt.data = loc_rdata_in;
               s_nxt.st = cce_pkg::ST_WR_REQ;
            end
         end
         cce_pkg::ST_WR_REQ: begin
            // write to host window or local bus [RULE11]
            a = s_r.dst;
            s_nxt.wdata = s_r.data;
            s_nxt.loc_we = 1'b1;
            s_nxt.host_we = 1'b1;
            if (in_aper(a)) begin
               s_nxt.host_req = 1'b1;
               s_nxt.host_addr = xlate(s_r.win_up[sel], s_r.win_lo[sel], a); // [RULE10]
            end else begin
               s_nxt.loc_req = 1'b1;
               s_nxt.loc_addr = a;
            end
            s_nxt.st = cce_pkg::ST_WR_WAIT;
         end
         cce_pkg::ST_WR_WAIT: begin
            // on write acceptance step pointers, finish on the last byte
            if ((s_r.host_req && host_ack_in) || (s_r.loc_req && loc_ack_in)) begin
               s_nxt.host_req = 1'b0;
               s_nxt.loc_req = 1'b0;
               s_nxt.src = s_r.src + 32'h1;
               s_nxt.dst = s_r.dst + 32'h1;
               s_nxt.btt = s_r.btt - 23'h1;
               if (s_r.btt == 23'h1) begin
                  s_nxt.idle = 1'b1; // [RULE15]
                  s_nxt.irq = s_r.ctrl[cce_pkg::CTRL_IRQ_BIT]; // [RULE2]
                  s_nxt.st = cce_pkg::ST_IDLE;
               end else begin
                  s_nxt.st = cce_pkg::ST_RD_REQ;
               end
            end
         end
         default: s_nxt.st = cce_pkg::ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s_r <= '0;
         s_r.st <= cce_pkg::ST_IDLE;
         s_r.ctrl <= cce_pkg::CTRL_RST;
         s_r.src <= cce_pkg::ADDR_RST;
         s_r.dst <= cce_pkg::ADDR_RST;
         s_r.idle <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state flops
   assign reg_rdata_out = s_r.rdata;
   assign reg_rvalid_out = s_r.rvalid;
   assign idle_out = s_r.idle;
   assign irq_out = s_r.irq;
   assign loc_req_out = s_r.loc_req;
   assign loc_we_out = s_r.loc_we;
   assign loc_addr_out = s_r.loc_addr;
   assign loc_wdata_out = s_r.wdata;
   assign host_req_out = s_r.host_req;
   assign host_we_out = s_r.host_we;
   assign host_addr_out = s_r.host_addr;
   assign host_wdata_out = s_r.wdata;

   // checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   property p_launch;
      wr_btt && idle_out && (reg_wdata_in[22:0] != 23'h0) |=> !idle_out ##1 (s_r.loc_req || s_r.host_req);
   endproperty
   a_launch: assert property (p_launch) else $error("launch did not start engine"); // [RULE5]
   property p_zero;
      wr_btt && idle_out && (reg_wdata_in[22:0] == 23'h0) |=> s_r.err && idle_out;
   endproperty
   a_zero: assert property (p_zero) else $error("zero count not flagged"); // [RULE14]
   property p_irq;
      irq_out |-> idle_out && s_r.ctrl[cce_pkg::CTRL_IRQ_BIT] && $past(s_r.st == cce_pkg::ST_WR_WAIT);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without enabled completion"); // [RULE2]
   property p_idle_rise;
      $rose(idle_out) |-> $past(s_r.loc_req || s_r.host_req) && $past(s_r.btt) == 23'h1;
   endproperty
   a_idle_rise: assert property (p_idle_rise) else $error("idle set before last write"); // [RULE15]
   property p_src;
      reg_wr_in && reg_addr_in == cce_pkg::OFS_SRC && idle_out |=> s_r.src == $past(reg_wdata_in);
   endproperty
   a_src: assert property (p_src) else $error("source address not loaded"); // [RULE3]
   property p_dst;
      reg_wr_in && reg_addr_in == cce_pkg::OFS_DST && idle_out |=> s_r.dst == $past(reg_wdata_in);
   endproperty
   a_dst: assert property (p_dst) else $error("destination address not loaded"); // [RULE4]
   property p_stat;
      reg_rd_in && reg_addr_in == cce_pkg::OFS_STAT |=> reg_rvalid_out && reg_rdata_out[1] == $past(idle_out);
   endproperty
   a_stat: assert property (p_stat) else $error("status idle bit wrong"); // [RULE1]
   property p_unused;
      reg_rd_in && reg_addr_in >= cce_pkg::OFS_UNUSED_LO && reg_addr_in <= cce_pkg::OFS_UNUSED_HI
         |=> reg_rdata_out == 32'h0;
   endproperty
   a_unused: assert property (p_unused) else $error("unused range not zero"); // [RULE12]
   property p_xlate;
      $rose(host_req_out) && !s_r.ctrl[cce_pkg::CTRL_WSEL_BIT]
         |-> host_addr_out[63:19] == {s_r.win_up[0], s_r.win_lo[0][31:19]};
   endproperty
   a_xlate: assert property (p_xlate) else $error("host address upper bits wrong"); // [RULE10]
   property p_aper;
      $rose(host_req_out)
         |-> host_addr_out[18:0] == (host_we_out ? $past(s_r.dst[18:0]) : $past(s_r.src[18:0]));
   endproperty
   a_aper: assert property (p_aper) else $error("aperture offset lost"); // [RULE8]
   property p_win;
      reg_wr_in && reg_addr_in == cce_pkg::OFS_W1L |=> s_r.win_lo[1] == $past(reg_wdata_in);
   endproperty
   a_win: assert property (p_win) else $error("window register not loaded"); // [RULE13]

   c_launch: cover property (wr_btt && idle_out ##1 !idle_out);
   c_host: cover property ($rose(host_req_out));
   c_done: cover property ($rose(idle_out));
   c_zero: cover property ($rose(s_r.err));
endmodule : cce_copy_engine

// ---- tb/cce_far_model.sv ----
`timescale 1ns/1ps
// far side memory: answers one byte request after a variable wait
module cce_far_model (
   // clock
   input wire logic clk_in,
   // request from the engine
   input wire logic req_in,
   input wire logic [63:0] addr_in,
   // wait in cycles before the answer
   input wire logic [1:0] lat_in,
   // answer
   output logic ack_out,
   output logic [7:0] rdata_out
);
   int waited = 0; // cycles spent on the open request
   initial ack_out = 1'b0;
   initial rdata_out = 8'h00;
   // one-cycle ack; the data line toggles while no request is open and holds during the wait
   always @(posedge clk_in) begin
      if (ack_out || !req_in) begin
         ack_out <= 1'b0;
         rdata_out <= ~rdata_out;
         waited <= 0;
      end else if (waited >= lat_in) begin
         ack_out <= 1'b1;
         rdata_out <= addr_in[7:0] ^ addr_in[15:8] ^ 8'h5a;
      end else begin
         waited <= waited + 1;
      end
   end
endmodule : cce_far_model

// ---- tb/cce_copy_engine_tb_top.sv ----
`timescale 1ns/1ps
// self-checking bench for the copy engine
module cce_copy_engine_tb_top;
   logic clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic [15:0] reg_addr_in = 16'h0000;
   logic [31:0] reg_wdata_in = 32'h0000_0000;
   logic [31:0] phy_status_in = 32'h0000_0000;
   logic [1:0] lat_l = 2'h0;
   logic [1:0] lat_h = 2'h0;
   logic [31:0] reg_rdata_out, loc_addr_out, v;
   logic [63:0] host_addr_out;
   logic [7:0] loc_wdata_out, host_wdata_out, loc_rdata_in, host_rdata_in;
   logic reg_rvalid_out, idle_out, irq_out, loc_req_out, loc_we_out, loc_ack_in;
   logic host_req_out, host_we_out, host_ack_in;
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   int irqs = 0;
   int seed = 32'hcdcde698;
   logic [31:0] wu [2]; // window upper words
   logic [31:0] wl [2]; // window lower words
   logic [73:0] exp_q [$]; // expected {port, we, addr, data} per access
   cce_copy_engine i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .phy_status_in(phy_status_in),
      .idle_out(idle_out), .irq_out(irq_out), .loc_req_out(loc_req_out), .loc_we_out(loc_we_out),
      .loc_addr_out(loc_addr_out), .loc_wdata_out(loc_wdata_out), .loc_ack_in(loc_ack_in),
      .loc_rdata_in(loc_rdata_in), .host_req_out(host_req_out), .host_we_out(host_we_out),
      .host_addr_out(host_addr_out), .host_wdata_out(host_wdata_out), .host_ack_in(host_ack_in),
      .host_rdata_in(host_rdata_in));
   cce_far_model i_loc (.clk_in(clk_in), .req_in(loc_req_out), .addr_in({32'h0, loc_addr_out}),
      .lat_in(lat_l), .ack_out(loc_ack_in), .rdata_out(loc_rdata_in));
   cce_far_model i_host (.clk_in(clk_in), .req_in(host_req_out), .addr_in(host_addr_out),
      .lat_in(lat_h), .ack_out(host_ack_in), .rdata_out(host_rdata_in));
   // clock generator
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   // compare one value and count it
   task automatic chk(input string n, input logic [73:0] e, input logic [73:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // print counts and verdict, then stop
   task automatic wrap_up();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   // bus address to {host port, target address}
   function automatic logic [64:0] map(input logic [31:0] a, input logic s);
      if (a >= 32'h0008_0000 && a <= 32'h000f_ffff)
         return {1'b1, wu[s], wl[s][31:19], a[18:0]};
      return {1'b0, 32'h0, a};
   endfunction : map
   // one register write
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge clk_in);
      reg_wr_in = 1'b1;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(negedge clk_in);
      reg_wr_in = 1'b0;
   endtask : wr
   // one register read, answer one cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [31:0] d);
      @(negedge clk_in);
      reg_rd_in = 1'b1;
      reg_addr_in = a;
      @(negedge clk_in);
      reg_rd_in = 1'b0;
      chk("rvalid", 74'h1, reg_rvalid_out);
      d = reg_rdata_out;
   endtask : rd
   // program, launch and poll one transfer; predicts every access
   task automatic xfer(input logic [31:0] s, input logic [31:0] d, input int n, input logic [31:0] c);
      logic [64:0] m;
      logic [7:0] b;
      int i;
      wr(16'h0000, c);
      wr(16'h0018, s);
      wr(16'h0020, d);
      for (i = 0; i < n; i++) begin
         m = map(s + i, c[16]);
         b = m[7:0] ^ m[15:8] ^ 8'h5a;
         exp_q.push_back({m[64], 1'b0, m[63:0], 8'h00});
         m = map(d + i, c[16]);
         exp_q.push_back({m[64], 1'b1, m[63:0], b});
      end
      wr(16'h0028, n);
      chk("idle", n == 0, idle_out);
      wr(16'h0018, 32'h0000_1111); // refused while busy
      v = 32'h0;
      for (i = 0; i < 300 && v[1] !== 1'b1; i++) rd(16'h0004, v);
      chk("idle", 74'h1, idle_out);
      chk("pending", 74'h0, exp_q.size());
      rd(16'h0018, v);
      chk("src", n == 0 ? 32'h0000_1111 : s + n, v);
   endtask : xfer
   // drive random waits; count cycles and irq pulses; compare each access
   always @(negedge clk_in) begin
      lat_l <= $random(seed);
      lat_h <= $random(seed);
   end
   // outputs are looked at mid-cycle, where they have settled
   always @(negedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         wrap_up();
      end
      if (irq_out === 1'b1)
         irqs <= irqs + 1;
      if (loc_req_out && loc_ack_in)
         chk("local", exp_q.size() ? exp_q.pop_front() : '1,
            {1'b0, loc_we_out, 32'h0, loc_addr_out, loc_we_out ? loc_wdata_out : 8'h00});
      if (host_req_out && host_ack_in)
         chk("host", exp_q.size() ? exp_q.pop_front() : '1,
            {1'b1, host_we_out, host_addr_out, host_we_out ? host_wdata_out : 8'h00});
   end
   // main sequence
   initial begin
      wu[1] = $random(seed);
      wl[1] = $random(seed);
      wu[0] = 32'h0000_3330;
      wl[0] = 32'h1234_5678;
      phy_status_in = $random(seed);
      repeat (20) @(negedge clk_in);
      reset_n_in = 1'b1;
      chk("idle", 74'h1, idle_out);
      rd(16'h1144, v);
      chk("phy", phy_status_in, v);
      rd(16'h1148, v);
      chk("unused", 74'h0, v);
      rd(16'h1204, v);
      chk("unused", 74'h0, v);
      for (int k = 0; k < 4; k++) wr(16'h1208 + 16'(4 * k), k[0] ? wl[k / 2] : wu[k / 2]);
      for (int k = 0; k < 4; k++) begin
         rd(16'h1208 + 16'(4 * k), v);
         chk("window", k[0] ? wl[k / 2] : wu[k / 2], v);
      end
      xfer(32'h000c_5678, 32'h0006_0000, 3, 32'h0000_1000);
      chk("irq", 74'h1, irqs);
      xfer(32'h0004_0010, 32'h000f_fffe, 2, 32'h0001_0000);
      xfer(32'h0007_fffe, 32'h0000_0100, 3, 32'h0000_1000);
      chk("irq", 74'h2, irqs);
      xfer(32'h0000_0200, 32'h0000_0300, 0, 32'h0000_1000);
      rd(16'h0004, v);
      chk("error", 74'h12, v & 32'h12);
      wr(16'h0004, 32'h0000_0010);
      rd(16'h0004, v);
      chk("error", 74'h2, v & 32'h12);
      chk("irq", 74'h2, irqs);
      wrap_up();
   end
endmodule : cce_copy_engine_tb_top
